// ==== rtl/sarb_buffer.v ====
// sarb_buffer.v: circular result buffer with serial register port
// assumes: converter on clk feeds tagged results in its own scan order;
// serial pins are asynchronous and sampled by clk (mode 0 framing)
`timescale 1ns/1ps
`include "sarb_defines.vh"
module sarb_buffer (
  input wire clk,
  input wire rst_n,
  input wire buf_en,
  input wire buf_clear,
  input wire continuous,
  input wire [5:0] trig_level,
  input wire res_valid,
  input wire [11:0] res_data,
  input wire res_tag,
  output wire res_ready,
  input wire sclk,
  input wire ss_n,
  input wire mosi,
  output reg miso,
  output reg miso_oe,
  output reg data_avail,
  output reg conv_run,
  output reg [1:0] buf_status
);
  // ring store and indices (index 0 is location 1)
  reg [`SARB_ENTRY_W-1:0] mem [0:63];
  reg [5:0] read_index_r;
  reg [5:0] write_index_r;
  reg [5:0] trigger_index_r;
  reg [6:0] count_r;
  reg [7:0] ctrl_r;
  reg read_start_r;
  reg pop_r;
  reg word_busy_r;

  // serial port state
  wire sclk_s;
  wire ss_n_s;
  wire mosi_s;
  reg sclk_d_r;
  reg [2:0] bit_cnt_r;
  reg data_phase_r;
  reg [6:0] addr_r;
  reg rw_r;
  reg [7:0] shin_r;
  reg [7:0] shout_r;
  reg [15:0] word_r;
  reg hi_done_r;
  reg low_sel_r;

  // staging fifo outputs
  wire stage_valid;
  wire [`SARB_ENTRY_W-1:0] stage_data;
  wire stage_ready;

  wire full = (count_r == `SARB_DEPTH);
  wire empty = (count_r == `SARB_COUNT_RST);
  wire clr = buf_clear | ~buf_en;
  wire port_i2c = ctrl_r[`SARB_CTRL_PORT_BIT];
  wire [5:0] lvl_m1 = trig_level - 6'h01;

  sarb_sync #(
    .W(3),
    .RV(3'b010)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({sclk, ss_n, mosi}),
    .dout({sclk_s, ss_n_s, mosi_s})
  );

  // results keep their arrival order through the staging fifo
  sarb_fifo #(
    .W(`SARB_ENTRY_W),
    .D(`SARB_STAGE_DEPTH),
    .AW(`SARB_STAGE_AW)
  ) u_stage (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data({res_tag, res_data}),
    .out_valid(stage_valid),
    .out_ready(stage_ready),
    .out_data(stage_data)
  );

  // serial edges and the byte boundary
  wire rise = sclk_s & ~sclk_d_r & ~ss_n_s;
  wire fall = ~sclk_s & sclk_d_r & ~ss_n_s;
  wire byte_done = rise & (bit_cnt_r == `SARB_BITS_PER_BYTE);
  wire [7:0] in_byte = {shin_r[6:0], mosi_s};
  // address of the byte about to be shifted out, and whether to load
  wire [6:0] load_addr = data_phase_r ? addr_r + 7'h01 : in_byte[7:1];
  wire load = byte_done & (data_phase_r ? rw_r : mosi_s);
  wire hi_load = load & (load_addr == `SARB_ADDR_WORD_HIGH) & ~port_i2c;
  wire lo_load = load & (load_addr == `SARB_ADDR_WORD_LOW) & ~port_i2c;

  // word as it stands at the read index
  wire [15:0] cur_word = {full, (count_r <= 7'h01), 1'b0,
                          mem[read_index_r]};

  // automatic hold covers the whole word read; software hold on request
  wire halt = ctrl_r[`SARB_CTRL_SWHOLD_BIT] ?
              ctrl_r[`SARB_CTRL_HOLD_BIT] :
              (word_busy_r | hi_load);
  wire do_wr = stage_valid & ~halt & buf_en & ~clr;
  assign stage_ready = do_wr;
  wire pop_ok = pop_r & ~empty;
  wire hit = do_wr & (write_index_r == trigger_index_r);

  reg [7:0] load_byte;
  always @* begin
    load_byte = `SARB_BYTE_ZERO;
    case (load_addr)
      `SARB_ADDR_WORD_HIGH: begin
        if (!port_i2c)
          load_byte = {cur_word[15:12], cur_word[11:8]};
      end
      `SARB_ADDR_WORD_LOW: begin
        if (!port_i2c)
          load_byte = hi_done_r ? word_r[7:0] : cur_word[7:0];
      end
      `SARB_ADDR_UPD_CTRL: begin
        load_byte = ctrl_r;
      end
      default: begin
        load_byte = `SARB_BYTE_ZERO;
      end
    endcase
  end

  // ring store write port
  always @(posedge clk) begin
    if (do_wr)
      mem[write_index_r] <= stage_data;
  end

  // indices and fill count
  always @(posedge clk) begin
    if (!rst_n || clr) begin
      read_index_r <= `SARB_IDX_RST;
      write_index_r <= `SARB_IDX_RST;
      count_r <= `SARB_COUNT_RST;
    end else begin
      if (do_wr)
        write_index_r <= write_index_r + 6'h01;
      if (do_wr && pop_ok) begin
        read_index_r <= read_index_r + 6'h01;
      end else if (do_wr && full) begin
        read_index_r <= read_index_r + 6'h01;
      end else if (do_wr) begin
        count_r <= count_r + 7'h01;
      end else if (pop_ok) begin
        read_index_r <= read_index_r + 6'h01;
        count_r <= count_r - 7'h01;
      end
    end
  end

  // trigger, data available and conversion run control
  always @(posedge clk) begin
    if (!rst_n || clr) begin
      trigger_index_r <= lvl_m1;
      data_avail <= 1'b0;
      conv_run <= buf_en & rst_n;
    end else if (hit) begin
      data_avail <= 1'b1;
      if (continuous) begin
        trigger_index_r <= trigger_index_r + trig_level;
      end else begin
        conv_run <= 1'b0;
      end
    end else begin
      if (read_start_r || (continuous && do_wr))
        data_avail <= 1'b0;
      if (!continuous && !conv_run && read_start_r) begin
        conv_run <= 1'b1;
        trigger_index_r <= trigger_index_r + trig_level;
      end else if (continuous) begin
        conv_run <= 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      buf_status <= 2'b01;
    end else begin
      buf_status <= {full, empty};
    end
  end

  // serial slave: shift in on rising sclk, shift out on falling sclk
  always @(posedge clk) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      data_phase_r <= 1'b0;
      addr_r <= 7'h00;
      rw_r <= 1'b0;
      shin_r <= `SARB_BYTE_ZERO;
      shout_r <= `SARB_BYTE_ZERO;
      miso <= 1'b0;
      miso_oe <= 1'b0;
      ctrl_r <= `SARB_CTRL_RST;
      word_r <= 16'h4000;
      hi_done_r <= 1'b0;
      low_sel_r <= 1'b0;
      word_busy_r <= 1'b0;
      read_start_r <= 1'b0;
      pop_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      miso_oe <= ~ss_n_s;
      read_start_r <= hi_load;
      pop_r <= byte_done & data_phase_r & low_sel_r;
      if (ss_n_s) begin
        bit_cnt_r <= 3'h0;
        data_phase_r <= 1'b0;
        hi_done_r <= 1'b0;
        low_sel_r <= 1'b0;
        word_busy_r <= 1'b0;
        shout_r <= `SARB_BYTE_ZERO;
        miso <= 1'b0;
      end else begin
        if (rise) begin
          shin_r <= in_byte;
          bit_cnt_r <= bit_cnt_r + 3'h1;
        end
        if (fall) begin
          miso <= shout_r[7];
          shout_r <= {shout_r[6:0], 1'b0};
        end
        if (byte_done) begin
          if (!data_phase_r) begin
            addr_r <= in_byte[7:1];
            rw_r <= mosi_s;
            data_phase_r <= 1'b1;
          end else begin
            if (!rw_r && addr_r == `SARB_ADDR_UPD_CTRL)
              ctrl_r <= in_byte & `SARB_CTRL_MASK;
            addr_r <= addr_r + 7'h01;
            if (low_sel_r)
              word_busy_r <= 1'b0;
          end
          shout_r <= load ? load_byte : `SARB_BYTE_ZERO;
          hi_done_r <= hi_load;
          low_sel_r <= lo_load & hi_done_r;
          if (hi_load) begin
            word_r <= cur_word;
            word_busy_r <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ==== rtl/sarb_defines.vh ====
// sarb_defines.vh: constants of the sar result circular buffer
// assumes inclusion by bare name from the sarb buffer design file
`ifndef SARB_DEFINES_VH
`define SARB_DEFINES_VH
// circular store
`define SARB_DEPTH 7'h40
`define SARB_IDX_W 6
`define SARB_ENTRY_W 13
// staging fifo in the data path
`define SARB_STAGE_DEPTH 16
`define SARB_STAGE_AW 4
// register addresses of the serial port
`define SARB_ADDR_WORD_HIGH 7'h01
`define SARB_ADDR_WORD_LOW 7'h02
`define SARB_ADDR_UPD_CTRL 7'h12
// buffer_update_control fields
`define SARB_CTRL_PORT_BIT 7
`define SARB_CTRL_SWHOLD_BIT 6
`define SARB_CTRL_HOLD_BIT 5
`define SARB_CTRL_MASK 8'he0
`define SARB_CTRL_RST 8'h00
// buffered read word fields
`define SARB_WORD_FULL_BIT 15
`define SARB_WORD_EMPTY_BIT 14
`define SARB_WORD_TAG_BIT 12
// reset values, and the bit count at the last bit of a byte
`define SARB_IDX_RST 6'h00
`define SARB_COUNT_RST 7'h00
`define SARB_BYTE_ZERO 8'h00
`define SARB_BITS_PER_BYTE 3'h7
`endif

// ==== rtl/sarb_fifo.v ====
// sarb_fifo.v: small staging fifo with valid/ready on both sides
// assumes one clock; flags are registered
`timescale 1ns/1ps
module sarb_fifo #(
  parameter W = 13,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  reg [AW:0] cnt_nxt;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign out_data = mem[rp_r];

  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop & ~push)
      cnt_nxt = cnt_r - 1'b1;
  end

  always @(posedge clk) begin
    if (push)
      mem[wp_r] <= in_data;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != D[AW:0]);
      out_valid <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end
endmodule

// ==== rtl/sarb_sync.v ====
// sarb_sync.v: two-flop synchroniser, one bit per lane
// assumes inputs from outside the clk domain; reset value per lane
`timescale 1ns/1ps
module sarb_sync #(
  parameter W = 1,
  parameter [W-1:0] RV = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= RV;
      dout <= RV;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

// ==== tb/sarb_buffer_asserts.sv ====
// sarb_buffer_asserts.sv: port checker for sarb_buffer
// assumes it is bound onto sarb_buffer by the line at the foot
`timescale 1ns/1ps
module sarb_buffer_asserts (
  input wire clk,
  input wire rst_n,
  input wire buf_en,
  input wire buf_clear,
  input wire continuous,
  input wire [5:0] trig_level,
  input wire res_valid,
  input wire [11:0] res_data,
  input wire res_tag,
  input wire res_ready,
  input wire sclk,
  input wire ss_n,
  input wire mosi,
  input wire miso,
  input wire miso_oe,
  input wire data_avail,
  input wire conv_run,
  input wire [1:0] buf_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_oe; ss_n [*5] |-> !miso_oe; endproperty
  a_oe: assert property (p_oe) else $error("miso driven while idle");
  property p_st; buf_status != 2'b11; endproperty
  a_st: assert property (p_st) else $error("full and empty");
  property p_pause; data_avail && !continuous |-> !conv_run; endproperty
  a_pause: assert property (p_pause) else $error("no pause");
  property p_cont;
    continuous && buf_en && !buf_clear ##1 continuous && buf_en |-> conv_run;
  endproperty
  a_cont: assert property (p_cont) else $error("converter stopped");
  property p_clr; buf_clear [*2] |=> buf_status == 2'b01 && !data_avail;
  endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_da; buf_status[0] [*2] |-> !data_avail; endproperty
  a_da: assert property (p_da) else $error("flag while empty");
  property p_rdy; $fell(res_ready) |-> $past(res_valid); endproperty
  a_rdy: assert property (p_rdy) else $error("ready dropped");
  property p_off; !buf_en |=> !conv_run && !data_avail; endproperty
  a_off: assert property (p_off) else $error("active while off");
  c_da: cover property (data_avail ##1 !data_avail);
  c_full: cover property (buf_status == 2'b10);
  c_stall: cover property (res_valid && !res_ready);
endmodule
bind sarb_buffer sarb_buffer_asserts u_chk (.*);

// ==== tb/sarb_host_model.sv ====
// sarb_host_model.sv: serial host, mode 0, sclk period 8 clk
// assumes clk of 10 ns; select released between frames
`timescale 1ns/1ps
module sarb_host_model (
  input wire clk,
  input wire miso,
  output logic sclk,
  output logic ss_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // miso taken late in the high phase of each of tx bits 15 to 0, after it has settled
  task automatic frame(input logic [23:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'h0000;
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 23; i > 23 - n; i--) begin
      mosi <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      if (i < 16) rx[i] = miso;
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    ss_n <= 1'b1;
    mosi <= ~tx[24 - n];
    repeat (8) @(posedge clk);
  endtask
endmodule

// ==== tb/test_sar_result_circular_buffer.sv ====
// test_sar_result_circular_buffer.sv: self-checking bench for sarb_buffer
// assumes sarb_host_model on the serial pins and the bound checker
`timescale 1ns/1ps
module test_sar_result_circular_buffer;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic buf_en = 1'b0;
  logic buf_clear = 1'b0;
  logic continuous = 1'b0;
  logic res_valid = 1'b0;
  logic res_tag = 1'b0;
  logic [5:0] trig_level = 6'h04;
  logic [11:0] res_data = 12'h000;
  logic [15:0] rx;
  wire sclk, ss_n, mosi, miso, miso_oe, data_avail, conv_run, res_ready;
  wire [1:0] buf_status;
  int err_count = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  sarb_buffer dut (.*);
  sarb_host_model host (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // holds valid until the word is taken; caller lowers it
  task automatic push(input logic [11:0] d, input logic t);
    res_valid <= 1'b1;
    res_data <= d;
    res_tag <= t;
    do @(negedge clk); while (res_ready !== 1'b1);
    @(posedge clk);
  endtask
  task automatic stop;
    res_valid <= 1'b0;
    tick(4);
  endtask
  task automatic clear(input logic c, input logic [5:0] lvl);
    buf_clear <= 1'b1;
    trig_level <= lvl;
    tick(3);
    buf_clear <= 1'b0;
    continuous <= c;
    tick(1);
  endtask
  task automatic wr(input logic [7:0] v);
    host.frame({7'h12, 1'b0, v, 8'h00}, 16, rx);
  endtask
  task automatic rd(input logic [6:0] a);
    host.frame({a, 1'b1, 16'h0000}, 24, rx);
  endtask
  task automatic t_regs;
    chk({miso_oe, data_avail, conv_run, buf_status}, 16'h0001);
    rd(7'h12);
    chk(rx, 16'h0000);
    wr(8'hff);
    rd(7'h12);
    chk(rx, 16'he000);
    rd(7'h01);
    chk(rx, 16'h0000);
    wr(8'h00);
  endtask
  task automatic t_single;
    clear(1'b0, 6'h04);
    for (int i = 0; i < 4; i++) push(12'h3a0 + 12'(i), i[0]);
    stop;
    chk({data_avail, conv_run}, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      rd(7'h01);
      chk(rx, {1'b0, i == 3, 1'b0, i[0], 12'h3a0 + 12'(i)});
      if (i == 0) chk({data_avail, conv_run}, 16'h0001);
    end
    rd(7'h01);
    chk(rx[14], 1'b1);
    push(12'h5c3, 1'b1);
    stop;
    rd(7'h01);
    chk(rx, 16'h55c3);
  endtask
  task automatic t_cont;
    clear(1'b1, 6'h02);
    push(12'h111, 1'b0);
    push(12'h222, 1'b1);
    stop;
    chk({data_avail, conv_run}, 16'h0003);
    push(12'h333, 1'b0);
    stop;
    chk(data_avail, 1'b0);
    push(12'h444, 1'b1);
    stop;
    chk(data_avail, 1'b1);
    rd(7'h01);
    chk(data_avail, 1'b0);
  endtask
  task automatic t_full;
    clear(1'b1, 6'h00);
    for (int i = 0; i < 65; i++) push(12'(i), 1'b0);
    stop;
    chk(buf_status, 2'b10);
    rd(7'h01);
    chk(rx, 16'h8001);
  endtask
  task automatic t_halt;
    clear(1'b1, 6'h00);
    wr(8'h60);
    for (int i = 0; i < 16; i++) push(12'(i), 1'b1);
    stop;
    chk({res_ready, buf_status}, 16'h0001);
    wr(8'h40);
    for (int i = 0; i < 16; i++) begin
      rd(7'h01);
      chk(rx, {1'b0, i == 15, 2'b01, 12'(i)});
    end
    chk(buf_status, 2'b01);
  endtask
  initial begin
    tick(16);
    rst_n <= 1'b1;
    tick(3);
    t_regs;
    buf_en <= 1'b1;
    tick(2);
    t_single;
    t_cont;
    t_full;
    t_halt;
    complete_run;
  end
  initial begin
    #1000000;
    err_count++;
    complete_run;
  end
endmodule
